// File: core/ecp_defs.svh
/*
 * Register offsets, field positions, reset values and timing counts of the
 * enhanced capture/compare/PWM unit.
 * Assumes byte addressing on a 32-bit APB bus, one register per word.
 */
`ifndef ECP_DEFS_SVH
`define ECP_DEFS_SVH

// Register byte offsets
`define ECP_OFF_CTRL      8'h00
`define ECP_OFF_DUTY_MSB  8'h04
`define ECP_OFF_ACTIVE    8'h08
`define ECP_OFF_PERIOD    8'h0c
`define ECP_OFF_TCTRL     8'h10
`define ECP_OFF_STATUS    8'h14
`define ECP_OFF_TCOUNT    8'h18
`define ECP_OFF_CCTIMER   8'h1c

// Control register fields
`define ECP_CFG_HI        7
`define ECP_CFG_LO        6
`define ECP_DLSB_HI       5
`define ECP_DLSB_LO       4
`define ECP_MODE_HI       3
`define ECP_MODE_LO       0

// Timer control fields
`define ECP_TC_CC_RUN     3
`define ECP_TC_RUN        2
`define ECP_TC_PS_HI      1
`define ECP_TC_PS_LO      0

// Status fields
`define ECP_ST_FLAG       0

// Reset values
`define ECP_RST_CTRL      8'h00
`define ECP_RST_BYTE      8'h00
`define ECP_RST_PERIOD    8'hff
`define ECP_RST_TCTRL     4'h0

// Mode select codes
`define ECP_M_OFF         4'h0
`define ECP_M_TOGGLE      4'h2
`define ECP_M_CAP_ANY     4'h3
`define ECP_M_CAP_FALL    4'h4
`define ECP_M_CAP_RISE    4'h5
`define ECP_M_CAP_RISE4   4'h6
`define ECP_M_CAP_RISE16  4'h7
`define ECP_M_SET_HI      4'h8
`define ECP_M_SET_LO      4'h9
`define ECP_M_SOFT        4'ha
`define ECP_M_SPECIAL     4'hb

// Last fine-count value per timer increment (4 clocks times prescale, less one), then last capture prescale count
`define ECP_FINE_LAST_1   6'h03
`define ECP_FINE_LAST_4   6'h0f
`define ECP_FINE_LAST_16  6'h3f
`define ECP_CAP_LAST_4    4'h3
`define ECP_CAP_LAST_16   4'hf

`endif

// File: core/ecp_pkg.sv
/*
 * Types shared by the enhanced capture/compare/PWM unit.
 * Assumes nothing of its surroundings.
 */
package ecp_pkg;

    // Output configuration in PWM mode, in field order 00..11
    typedef enum logic [1:0] {
        ECP_SINGLE,
        ECP_BRIDGE_FWD,
        ECP_HALF_BRIDGE,
        ECP_BRIDGE_REV
    } ecp_outcfg_t;

    typedef logic [7:0] ecp_byte_t;
    typedef logic [9:0] ecp_duty_t;

endpackage : ecp_pkg

// File: core/ecp_tb_if.sv
/*
 * Carrier between the unit and its period time base.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface ecp_tb_if;
    logic       run;       // Period timer enabled
    logic [1:0] ps_sel;    // Prescale select
    logic [7:0] period;    // Period match value
    logic [7:0] count;     // Period timer count
    logic [1:0] fine_lsb;  // Two extra low-order bits
    logic       wrap;      // Pulse: timer just cleared at period end

    modport core (output run, ps_sel, period, input count, fine_lsb, wrap);
    modport base (input run, ps_sel, period, output count, fine_lsb, wrap);
endinterface : ecp_tb_if

// File: core/ecp_timebase.sv
/*
 * Period timer with prescaler of 1, 4 or 16 on top of a quarter-cycle count.
 * Assumes pclk is the oscillator clock; one timer increment is
 * four clocks times the prescale ratio.
 */
`timescale 1ns/1ps
module ecp_timebase
    import ecp_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    ecp_tb_if.base    tb
);
`include "ecp_defs.svh"

    logic [5:0] fine_q;
    logic [5:0] fine_last;
    logic [7:0] count_q;
    logic       wrap_q;

    // Ratio 1, 4 or 16; code 1x both mean 16
    always_comb
    begin
        case (tb.ps_sel)
            2'b00:   fine_last = `ECP_FINE_LAST_1;
            2'b01:   fine_last = `ECP_FINE_LAST_4;
            default: fine_last = `ECP_FINE_LAST_16;
        endcase
    end

    // Fine count; its top two used bits extend the timer count
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            fine_q <= 6'h00;
        else if (!tb.run)
            fine_q <= 6'h00;
        else if (fine_q >= fine_last)
            fine_q <= 6'h00;
        else
            fine_q <= fine_q + 6'h01;
    end

    // Timer clears on the increment after it equals the period value
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count_q <= 8'h00;
            wrap_q  <= 1'b0;
        end
        else
        begin
            wrap_q <= 1'b0;
            if (tb.run && fine_q >= fine_last)
            begin
                if (count_q == tb.period)
                begin
                    count_q <= 8'h00;
                    wrap_q  <= 1'b1;
                end
                else
                    count_q <= count_q + 8'h01;
            end
        end
    end

    // Postscaling has no part in the period
    assign tb.count    = count_q;
    assign tb.wrap     = wrap_q;
    assign tb.fine_lsb = (tb.ps_sel == 2'b00) ? fine_q[1:0] :
                         (tb.ps_sel == 2'b01) ? fine_q[3:2] : fine_q[5:4];

endmodule : ecp_timebase

// File: core/ecp_unit.sv
/*
 * Enhanced capture/compare/PWM unit with APB register access.
 * Assumes pin direction and port muxing live outside: chN_own high means
 * the unit owns that channel, low hands it back to the port logic.
 */
`timescale 1ns/1ps
module ecp_unit
    import ecp_pkg::*;
#(
    parameter bit SPECIAL_EVENT_EN = 1'b1 // Low treats 1011 like 1010
)
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        capture_in,
    input  wire logic        adc_enable,
    output logic             adc_start,
    output logic             module_event_flag,
    output logic             channel_a_output,
    output logic             channel_b_output,
    output logic             channel_c_output,
    output logic             channel_d_output,
    output logic             channel_a_own,
    output logic             channel_b_own,
    output logic             channel_c_own,
    output logic             channel_d_own
);
`include "ecp_defs.svh"

    ecp_tb_if tb ();

    ecp_byte_t   ctrl_q;
    ecp_byte_t   duty_msb_q;
    ecp_byte_t   active_duty_q;
    logic [1:0]  active_lsb_q;
    ecp_byte_t   period_q;
    logic [3:0]  tctrl_q;
    logic [15:0] cc_timer_q;
    logic        flag_q;
    logic        pwm_q;
    logic        cc_pin_q;
    logic [3:0]  mode_prev_q;
    logic        cap_prev_q;
    logic [3:0]  cap_cnt_q;
    logic        adc_start_q;
    logic [31:0] prdata_q;
    logic        pslverr_q;
    logic [3:0]  ch_out_q;
    logic [3:0]  ch_own_q;

    logic [3:0]  mode;
    ecp_outcfg_t cfg;
    logic        pwm_mode;
    logic        cap_mode;
    logic        wr_acc;
    logic        setup;
    logic        mapped;
    logic        status_clr;
    logic        cc_match;
    logic        cap_edge;
    logic        cap_take;
    logic        special;
    logic        mode_new;
    logic [3:0]  ch_out_d;
    logic [3:0]  ch_own_d;
    logic [31:0] rd_val;

    assign mode     = ctrl_q[`ECP_MODE_HI:`ECP_MODE_LO];
    assign cfg      = ecp_outcfg_t'(ctrl_q[`ECP_CFG_HI:`ECP_CFG_LO]);
    assign pwm_mode = (mode[3:2] == 2'b11);
    assign cap_mode = (mode >= `ECP_M_CAP_ANY) &&
                      (mode <= `ECP_M_CAP_RISE16);
    assign mode_new = (mode != mode_prev_q);

    // Time base hookup
    assign tb.run    = tctrl_q[`ECP_TC_RUN];
    assign tb.ps_sel = tctrl_q[`ECP_TC_PS_HI:`ECP_TC_PS_LO];
    assign tb.period = period_q;

    ecp_timebase i_ecp_timebase (
        .pclk    (pclk),
        .presetn (presetn),
        .tb      (tb)
    );

    // APB decode; zero wait states, so pready is always high
    assign setup  = psel && !penable;
    assign wr_acc = psel && penable && pwrite;
    assign pready = 1'b1;
    assign mapped = (paddr[1:0] == 2'b00) && (paddr <= `ECP_OFF_CCTIMER);
    assign status_clr = wr_acc && (paddr == `ECP_OFF_STATUS) &&
                        pwdata[`ECP_ST_FLAG];

    // Control, duty, period and timer control registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q     <= `ECP_RST_CTRL;
            duty_msb_q <= `ECP_RST_BYTE;
            period_q   <= `ECP_RST_PERIOD;
            tctrl_q    <= `ECP_RST_TCTRL;
        end
        else if (wr_acc)
        begin
            case (paddr)
                `ECP_OFF_CTRL:     ctrl_q     <= pwdata[7:0];
                `ECP_OFF_DUTY_MSB: duty_msb_q <= pwdata[7:0];
                `ECP_OFF_PERIOD:   period_q   <= pwdata[7:0];
                `ECP_OFF_TCTRL:    tctrl_q    <= pwdata[3:0];
                default:           ;
            endcase
        end
    end

    // Compare/capture timer; special event clears it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cc_timer_q <= 16'h0000;
        else if (special)
            cc_timer_q <= 16'h0000;
        else if (tctrl_q[`ECP_TC_CC_RUN])
            cc_timer_q <= cc_timer_q + 16'h0001;
    end

    // Match only while the timer runs, so a stopped timer cannot refire
    assign cc_match = tctrl_q[`ECP_TC_CC_RUN] && !pwm_mode && !cap_mode &&
                      (mode != `ECP_M_OFF) && !mode_new &&
                      (cc_timer_q == {active_duty_q, duty_msb_q});
    assign special  = cc_match && SPECIAL_EVENT_EN &&
                      (mode == `ECP_M_SPECIAL);

    // Capture edge selection and prescale
    always_comb
    begin
        cap_edge = 1'b0;
        case (mode)
            `ECP_M_CAP_ANY:    cap_edge = capture_in ^ cap_prev_q;
            `ECP_M_CAP_FALL:   cap_edge = cap_prev_q && !capture_in;
            `ECP_M_CAP_RISE,
            `ECP_M_CAP_RISE4,
            `ECP_M_CAP_RISE16: cap_edge = !cap_prev_q && capture_in;
            default:           cap_edge = 1'b0;
        endcase
    end

    assign cap_take = cap_edge && !mode_new &&
        ((mode == `ECP_M_CAP_RISE4)  ? (cap_cnt_q == `ECP_CAP_LAST_4)  :
         (mode == `ECP_M_CAP_RISE16) ? (cap_cnt_q == `ECP_CAP_LAST_16) :
         1'b1);

    // Edge history and prescale count; a mode change restarts the count
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cap_prev_q  <= 1'b0;
            cap_cnt_q   <= 4'h0;
            mode_prev_q <= `ECP_M_OFF;
        end
        else
        begin
            cap_prev_q  <= capture_in;
            mode_prev_q <= mode;
            if (mode_new)
                cap_cnt_q <= 4'h0;
            else if (cap_take)
                cap_cnt_q <= 4'h0;
            else if (cap_edge)
                cap_cnt_q <= cap_cnt_q + 4'h1;
        end
    end

    // Active duty byte: period latch in PWM, compare/capture high byte
    // otherwise; the hidden two bits are only ever loaded at period end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            active_duty_q <= `ECP_RST_BYTE;
            active_lsb_q  <= 2'b00;
        end
        else if (pwm_mode && tb.wrap)
        begin
            active_duty_q <= duty_msb_q;
            active_lsb_q  <= ctrl_q[`ECP_DLSB_HI:`ECP_DLSB_LO];
        end
        else if (!pwm_mode && cap_take)
            active_duty_q <= cc_timer_q[15:8];
        else if (!pwm_mode && wr_acc && paddr == `ECP_OFF_ACTIVE)
            active_duty_q <= pwdata[7:0];
    end

    // Raw PWM waveform; wrap has priority over the clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pwm_q <= 1'b0;
        else if (!pwm_mode)
            pwm_q <= 1'b0;
        else if (tb.wrap)
            pwm_q <= ({duty_msb_q,
                       ctrl_q[`ECP_DLSB_HI:`ECP_DLSB_LO]} != 10'h000);
        else if ({tb.count, tb.fine_lsb} == {active_duty_q, active_lsb_q})
            pwm_q <= 1'b0;
    end

    // Compare pin latch: start level on mode entry, then match action
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cc_pin_q <= 1'b0;
        else if (mode == `ECP_M_OFF)
            cc_pin_q <= 1'b0;
        else if (mode_new && mode == `ECP_M_SET_HI)
            cc_pin_q <= 1'b0;
        else if (mode_new && mode == `ECP_M_SET_LO)
            cc_pin_q <= 1'b1;
        else if (cc_match && mode == `ECP_M_TOGGLE)
            cc_pin_q <= !cc_pin_q;
        else if (cc_match && mode == `ECP_M_SET_HI)
            cc_pin_q <= 1'b1;
        else if (cc_match && mode == `ECP_M_SET_LO)
            cc_pin_q <= 1'b0;
    end

    // Event flag: a new event in the clearing cycle wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            flag_q <= 1'b0;
        else if (cc_match || cap_take)
            flag_q <= 1'b1;
        else if (status_clr)
            flag_q <= 1'b0;
    end

    // Conversion start pulse, only when the converter is enabled
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            adc_start_q <= 1'b0;
        else
            adc_start_q <= special && adc_enable;
    end

    // Channel steering; index 0..3 is A..D, polarity bit 1 for A/C
    // and bit 0 for B/D. Dead band is not modelled in half bridge.
    always_comb
    begin
        ch_out_d = 4'h0;
        ch_own_d = 4'h0;
        if (!pwm_mode)
        begin
            ch_own_d[0] = (mode == `ECP_M_TOGGLE) ||
                          (mode == `ECP_M_SET_HI) ||
                          (mode == `ECP_M_SET_LO);
            ch_out_d[0] = cc_pin_q;
        end
        else
        begin
            case (cfg)
                ECP_SINGLE:
                begin
                    ch_own_d    = 4'b0001;
                    ch_out_d[0] = pwm_q;
                end
                ECP_BRIDGE_FWD:
                begin
                    ch_own_d = 4'b1111;
                    ch_out_d = {pwm_q, 1'b0, 1'b0, 1'b1};
                end
                ECP_HALF_BRIDGE:
                begin
                    ch_own_d = 4'b0011;
                    ch_out_d = {2'b00, !pwm_q, pwm_q};
                end
                ECP_BRIDGE_REV:
                begin
                    ch_own_d = 4'b1111;
                    ch_out_d = {1'b0, 1'b1, pwm_q, 1'b0};
                end
                default:
                begin
                    ch_own_d = 4'h0;
                    ch_out_d = 4'h0;
                end
            endcase
            ch_out_d = ch_out_d ^ {mode[0], mode[1], mode[0], mode[1]};
        end
    end

    // Registered pin drive, one flop pair per channel
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_ch
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    ch_out_q[gi] <= 1'b0;
                    ch_own_q[gi] <= 1'b0;
                end
                else
                begin
                    ch_out_q[gi] <= ch_out_d[gi] && ch_own_d[gi];
                    ch_own_q[gi] <= ch_own_d[gi];
                end
            end
        end
    endgenerate

    // Read mux
    always_comb
    begin
        case (paddr)
            `ECP_OFF_CTRL:     rd_val = {24'h000000, ctrl_q};
            `ECP_OFF_DUTY_MSB: rd_val = {24'h000000, duty_msb_q};
            `ECP_OFF_ACTIVE:   rd_val = {24'h000000, active_duty_q};
            `ECP_OFF_PERIOD:   rd_val = {24'h000000, period_q};
            `ECP_OFF_TCTRL:    rd_val = {28'h0000000, tctrl_q};
            `ECP_OFF_STATUS:   rd_val = {31'h0, flag_q};
            `ECP_OFF_TCOUNT:   rd_val = {24'h000000, tb.count};
            `ECP_OFF_CCTIMER:  rd_val = {16'h0000, cc_timer_q};
            default:           rd_val = 32'h00000000;
        endcase
    end

    // Read data and error are captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_q  <= 32'h00000000;
            pslverr_q <= 1'b0;
        end
        else if (setup)
        begin
            prdata_q  <= pwrite ? 32'h00000000 : rd_val;
            pslverr_q <= !mapped;
        end
    end

    assign prdata            = prdata_q;
    assign pslverr           = pslverr_q && psel && penable;
    assign adc_start         = adc_start_q;
    assign module_event_flag = flag_q;
    assign channel_a_output  = ch_out_q[0];
    assign channel_b_output  = ch_out_q[1];
    assign channel_c_output  = ch_out_q[2];
    assign channel_d_output  = ch_out_q[3];
    assign channel_a_own     = ch_own_q[0];
    assign channel_b_own     = ch_own_q[1];
    assign channel_c_own     = ch_own_q[2];
    assign channel_d_own     = ch_own_q[3];

endmodule : ecp_unit

// File: test/ecp_unit_asserts.sv
/* Port checker for the capture/compare/PWM unit.
   Assumes one clock, pclk, and the active-low async reset presetn. */
`timescale 1ns/1ps
module ecp_unit_chk
#(
    parameter bit SPECIAL_EVENT_EN = 1'b1
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic adc_enable,
    input wire logic adc_start,
    input wire logic module_event_flag,
    input wire logic channel_a_own,
    input wire logic channel_b_own,
    input wire logic channel_c_own,
    input wire logic channel_d_own,
    input wire logic channel_d_output
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Access phase of a bus transfer
    sequence s_access;
        psel && penable;
    endsequence

    // Trigger pulse followed by the flag within a cycle
    sequence s_event;
        adc_start ##[0:1] module_event_flag;
    endsequence

    a_ready_const: assert property (s_access |-> pready)
        else $error("pready low in access phase");
    a_adc_pulse: assert property (adc_start |=> !adc_start)
        else $error("adc_start longer than one cycle");
    a_adc_flag: assert property (adc_start |-> s_event)
        else $error("adc_start without event flag");
    a_adc_cause: assert property (
        adc_start |-> SPECIAL_EVENT_EN && $past(adc_enable))
        else $error("adc_start while converter disabled");
    a_b_needs_a: assert property (channel_b_own |-> channel_a_own)
        else $error("channel b owned without channel a");
    a_cd_paired: assert property (channel_c_own == channel_d_own)
        else $error("channels c and d owned apart");
    // Only a write may take the sticky flag down
    a_flag_sticky: assert property (
        module_event_flag && !(psel && penable && pwrite)
        |=> module_event_flag)
        else $error("event flag dropped without a write");
    a_unowned_low: assert property (
        !channel_d_own [*2] |-> !channel_d_output)
        else $error("channel d driven while released");
endmodule : ecp_unit_chk

bind ecp_unit ecp_unit_chk #(.SPECIAL_EVENT_EN(SPECIAL_EVENT_EN)) i_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pready(pready), .adc_enable(adc_enable),
    .adc_start(adc_start), .module_event_flag(module_event_flag),
    .channel_a_own(channel_a_own), .channel_b_own(channel_b_own),
    .channel_c_own(channel_c_own), .channel_d_own(channel_d_own),
    .channel_d_output(channel_d_output));

// File: test/ecp_load.sv
/* Load on channel A: a pulled-down pin whose pulse is timed.
   Assumes it shares pclk with the unit. */
`timescale 1ns/1ps
module ecp_load
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        drive,
    input  wire logic        own,
    input  wire logic        arm,
    output logic             pin,
    output logic             done,
    output logic      [15:0] width,
    output logic      [15:0] span
);
    logic        last_q;
    logic [1:0]  st_q;
    logic [15:0] hi_q;
    logic [15:0] cnt_q;

    // Released pin falls to the pull-down, never keeps its last level
    assign pin = own & drive;

    // First rise after arm only starts the count, so no partial pulse
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            last_q <= 1'b0;
            st_q   <= 2'd0;
            cnt_q  <= 16'h0;
            done   <= 1'b0;
        end
        else
        begin
            last_q <= pin;
            cnt_q  <= cnt_q + 16'd1;
            done   <= 1'b0;
            if (arm)
                st_q <= 2'd1;
            if (!pin && last_q)
                hi_q <= cnt_q;
            if (pin && !last_q)
            begin
                cnt_q <= 16'd1;
                st_q  <= (st_q == 2'd1) ? 2'd2 : 2'd0;
                done  <= (st_q == 2'd2);
                width <= hi_q;
                span  <= cnt_q;
            end
        end
    end
endmodule : ecp_load

// File: test/test_ecp_unit.sv
/* Self-checking bench for the capture/compare/PWM unit.
   Assumes the unit, its checker and the load model are compiled. */
`timescale 1ns/1ps
`include "ecp_defs.svh"
module test_ecp_unit;
    logic        pclk       = 1'b0;
    logic        presetn    = 1'b0;
    logic        psel       = 1'b0;
    logic        penable    = 1'b0;
    logic        pwrite     = 1'b0;
    logic [7:0]  paddr      = 8'h00;
    logic [31:0] pwdata     = 32'h0;
    logic        capture_in = 1'b0;
    logic        arm        = 1'b0;
    logic        look_q     = 1'b0;
    logic        adc_seen   = 1'b0;
    logic        adc_en     = 1'b1;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        adc_start;
    logic        flag;
    logic [3:0]  owns;
    logic [3:0]  outs;
    logic        pin_a;
    logic        done;
    logic [15:0] width;
    logic [15:0] span;
    logic [32:0] e;
    logic [32:0] q[$];
    int          errors     = 0;
    int          num_checks = 0;
    // Compare modes: {mode, mask, before match, after match}
    logic [33:0] cm[6] = '{{4'h8, 10'h3ff, 10'h080, 10'h188},
        {4'h9, 10'h3ff, 10'h088, 10'h180}, {4'ha, 10'h3ff, 10'h0, 10'h100},
        {4'hb, 10'h3ff, 10'h0, 10'h300}, {4'h2, 10'h3ff, 10'h080, 10'h188},
        {4'hb, 10'h3ff, 10'h0, 10'h100}};

    ecp_unit i_ecp_unit (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .capture_in(capture_in), .adc_enable(adc_en), .adc_start(adc_start),
        .module_event_flag(flag), .channel_a_output(outs[3]),
        .channel_b_output(outs[2]), .channel_c_output(outs[1]),
        .channel_d_output(outs[0]), .channel_a_own(owns[3]),
        .channel_b_own(owns[2]), .channel_c_own(owns[1]),
        .channel_d_own(owns[0]));
    ecp_load i_ecp_load (.pclk(pclk), .presetn(presetn), .drive(outs[3]),
        .own(owns[3]), .arm(arm), .pin(pin_a), .done(done), .width(width),
        .span(span));

    // 200 MHz clock
    initial
        forever #2.5 pclk = ~pclk;

    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic conclude;
        if (errors == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : conclude

    // One transfer; a read notes its expected {pslverr, prdata} first
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [32:0] d);
        if (!w)
            q.push_back(d);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d[31:0];
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    // Note the masked pin state, then ask the monitor to look
    task automatic look(input logic [9:0] m, input logic [9:0] x);
        @(posedge pclk);
        q.push_back({13'h0, m, x});
        look_q <= 1'b1;
        @(posedge pclk);
        look_q <= 1'b0;
        @(posedge pclk);
    endtask : look

    task automatic do_reset;
        presetn  <= 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
    endtask : do_reset

    task automatic cap(input logic v);
        capture_in <= v;
        repeat (4) @(posedge pclk);
    endtask : cap

    // Scoring: each result takes the oldest note off the queue
    always @(posedge pclk)
    begin
        if (!presetn)
            adc_seen <= 1'b0;
        else if (adc_start === 1'b1)
            adc_seen <= 1'b1;
        if (psel && penable && pready && !pwrite)
            check({pslverr, prdata}, q.pop_front());
        if (look_q)
        begin
            e = q.pop_front();
            check(33'({adc_seen, flag, owns, outs} & e[19:10]), 33'(e[9:0]));
        end
        if (done === 1'b1)
        begin
            e = q.pop_front();
            check(33'(span), 33'(e[15:0]));
            check(33'(width + 16'd1 - e[31:16] <= 16'd2), 33'h1);
        end
    end

    initial
    begin
        logic [9:0] d;
        logic [3:0] v;
        void'($urandom(50));
        do_reset();
        // Reset values, then an unaligned and an unmapped offset
        apb(1'b0, `ECP_OFF_CTRL, 33'h0);
        apb(1'b0, `ECP_OFF_PERIOD, 33'hff);
        apb(1'b0, `ECP_OFF_TCTRL, 33'h0);
        apb(1'b0, 8'h02, 33'h1_0000_0000);
        apb(1'b0, 8'h20, 33'h1_0000_0000);
        // Pulse width and period at each prescale, in setup order
        for (int s = 0; s < 3; s++)
        begin
            d = 10'($urandom_range(15, 1));
            apb(1'b1, `ECP_OFF_PERIOD, 33'h3);
            apb(1'b1, `ECP_OFF_DUTY_MSB, {25'h0, d[9:2]});
            apb(1'b1, `ECP_OFF_TCTRL, {29'h0, 2'b01, 2'(s)});
            apb(1'b1, `ECP_OFF_CTRL, {27'h0, d[1:0], 4'hc});
            repeat (40 << (2 * s)) @(posedge pclk);
            q.push_back({17'(d << (2 * s)), 16'(16 << (2 * s))});
            arm <= 1'b1;
            @(posedge pclk);
            arm <= 1'b0;
            repeat (40 << (2 * s)) @(posedge pclk);
        end
        // New duty waits for the period end; active copy is read-only in PWM mode
        @(posedge pin_a);
        @(posedge pclk);
        apb(1'b1, `ECP_OFF_DUTY_MSB, 33'h2a);
        apb(1'b0, `ECP_OFF_ACTIVE, {25'h0, d[9:2]});
        repeat (300) @(posedge pclk);
        apb(1'b1, `ECP_OFF_ACTIVE, 33'h55);
        apb(1'b0, `ECP_OFF_ACTIVE, 33'h2a);
        // Every output layout and polarity, duty above period
        for (int c = 0; c < 16; c++)
        begin
            apb(1'b1, `ECP_OFF_CTRL, {25'h0, c[3:2], 4'b0011, c[1:0]});
            repeat (300) @(posedge pclk);
            v = {~c[1], c[0], c[1], ~c[0]};
            v = c[2] ? (c[3] ? ~v : v) : (v & (c[3] ? 4'hc : 4'h8));
            look(10'h0ff, {2'b00,
                c[2] ? 4'hf : (c[3] ? 4'hc : 4'h8), v});
        end
        // Compare modes from a fresh reset, match at count 0x30;
        // the last repeats the special event with the converter off
        for (int k = 0; k < 6; k++)
        begin
            do_reset();
            adc_en <= (k != 5);
            apb(1'b1, `ECP_OFF_DUTY_MSB, 33'h30);
            apb(1'b1, `ECP_OFF_CTRL, {29'h0, cm[k][33:30]});
            look(cm[k][29:20], cm[k][19:10]);
            apb(1'b1, `ECP_OFF_TCTRL, 33'h8);
            repeat (80) @(posedge pclk);
            look(cm[k][29:20], cm[k][9:0]);
        end
        apb(1'b1, `ECP_OFF_CTRL, 33'h0);
        look(10'h0ff, 10'h000);
        // Capture: any edge, falling, rising, 4th and 16th rising
        for (int k = 0; k < 5; k++)
        begin
            do_reset();
            apb(1'b1, `ECP_OFF_CTRL, 33'(k + 3));
            repeat (k == 3 ? 3 : (k == 4 ? 15 : 0))
            begin
                cap(1'b1);
                cap(1'b0);
            end
            look(10'h100, 10'h000);
            cap(1'b1);
            look(10'h100, k == 1 ? 10'h000 : 10'h100);
            cap(1'b0);
            look(10'h100, 10'h100);
        end
        // Sticky flag is cleared by writing one
        apb(1'b1, `ECP_OFF_STATUS, 33'h1);
        apb(1'b0, `ECP_OFF_STATUS, 33'h0);
        check(33'(q.size()), 33'h0);
        conclude();
    end

    // Watchdog well past the expected run of some 8k cycles
    initial
    begin
        #450000;
        errors++;
        conclude();
    end
endmodule : test_ecp_unit
